/* File: hdl/rsc_params.svh */
// Constants for the per-port repeater statistics block: attribute offsets,
// counter indices, frame and burst limits, and timer figures.
// Assumes it is included by the package, by the checker and by the bench.
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

`define RSC_NUM_PORTS       15
`define RSC_NUM_CNT         14
`define RSC_CNT_W           32
`define RSC_SA_W            48
`define RSC_CNT_BYTES       3'h4
`define RSC_SA_BYTES        3'h6

`define RSC_BANK_FIRST      8'h10
`define RSC_BANK_LAST       8'h1E

`define RSC_ADDR_OCTET      8'hE1
`define RSC_ADDR_CRC        8'hE2
`define RSC_ADDR_ALIGN      8'hE3
`define RSC_ADDR_OVERSIZE   8'hE4
`define RSC_ADDR_SHORT      8'hE5
`define RSC_ADDR_FRAG       8'hE6
`define RSC_ADDR_COLL       8'hE7
`define RSC_ADDR_LATE       8'hE8
`define RSC_ADDR_JABBER     8'hE9
`define RSC_ADDR_RATE       8'hEA
`define RSC_ADDR_PART       8'hEB
`define RSC_ADDR_SACHG      8'hEC
`define RSC_ADDR_BCAST      8'hED
`define RSC_ADDR_LAST_SA    8'hEE
`define RSC_ADDR_MCAST      8'hEF
`define RSC_ADDR_EXP_SA     8'hF0

`define RSC_CI_OCTET        4'h0
`define RSC_CI_CRC          4'h1
`define RSC_CI_ALIGN        4'h2
`define RSC_CI_OVERSIZE     4'h3
`define RSC_CI_SHORT        4'h4
`define RSC_CI_FRAG         4'h5
`define RSC_CI_COLL         4'h6
`define RSC_CI_LATE         4'h7
`define RSC_CI_JABBER       4'h8
`define RSC_CI_RATE         4'h9
`define RSC_CI_PART         4'hA
`define RSC_CI_SACHG        4'hB
`define RSC_CI_BCAST        4'hC
`define RSC_CI_MCAST        4'hD
`define RSC_CI_NONE         4'hF

`define RSC_MIN_FRAME_BYTES 11'h040
`define RSC_MAX_FRAME_BYTES 11'h5EE
`define RSC_RATE_MIN_BYTES  11'h200
`define RSC_SHORT_LIMIT_BT  10'h04C
`define RSC_MIN_FRAME_BT    10'h200
`define RSC_LATE_THRESH_BT  10'h200

`define RSC_JABBER_TIME_US  5000
`define RSC_CLK_MHZ         125
`define RSC_JAB_CNT_W       20

`endif

/* File: hdl/rsc_pkg.sv */
// Types for the per-port repeater statistics block.
// Assumes rsc_params.svh is reachable on the include path.
`include "rsc_params.svh"

package rsc_pkg;

  typedef logic [`RSC_NUM_PORTS-1:0][`RSC_NUM_CNT-1:0][`RSC_CNT_W-1:0] rsc_cnt_arr_type;
  typedef logic [`RSC_NUM_PORTS-1:0][`RSC_SA_W-1:0]                   rsc_sa_arr_type;

  typedef struct packed {
    logic [3:0]                bank;
    logic                      bank_ok;
    logic                      phase;
    logic [7:0]                attr;
    logic [2:0]                ridx;
    logic [2:0]                widx;
    logic [`RSC_SA_W-1:0]      hold;
    logic [`RSC_SA_W-9:0]      wbuf;
    logic [7:0]                rdata;
    logic [`RSC_NUM_PORTS-1:0] irq;
  } rsc_ctl_type;

  typedef struct packed {
    rsc_cnt_arr_type cnt;
    rsc_sa_arr_type  last_sa;
    rsc_sa_arr_type  exp_sa;
  } rsc_attr_type;

  typedef struct packed {
    rsc_ctl_type  ctl;
    rsc_attr_type attr;
  } rsc_state_type;

  typedef struct packed {
    logic [`RSC_JAB_CNT_W-1:0] cnt;
    logic                      fired;
    logic                      pulse;
  } rsc_jab_state_type;

endpackage : rsc_pkg

/* File: hdl/rsc_jabber_timer.sv */
// Transmit activity timer that flags one overlong transmission per burst.
// Assumes i_tx_active comes from logic on the same clock.
`timescale 1ns/1ns

module rsc_jabber_timer
  import rsc_pkg::*;
#(
  parameter logic [`RSC_JAB_CNT_W-1:0] LIMIT = `RSC_JAB_CNT_W'(625000)
)
(
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_ce,
  // Activity and expiry.
  input  wire logic i_tx_active,
  output logic      o_expire
);

  rsc_jab_state_type s_q;
  rsc_jab_state_type s_d;

  // ****************************************
  // Next state.
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    if (i_ce)
    begin
      s_d.pulse = 1'b0;
      if (!i_tx_active)
      begin
        s_d.cnt   = '0;
        s_d.fired = 1'b0;
      end
      else if (!s_q.fired)
      begin
        s_d.cnt = s_q.cnt + `RSC_JAB_CNT_W'(1);
        if (s_d.cnt >= LIMIT)
        begin
          s_d.fired = 1'b1;
          s_d.pulse = 1'b1;
        end
      end
    end
  end

  // ****************************************
  // State register.
  // ****************************************
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_expire = s_q.pulse;

endmodule : rsc_jabber_timer

/* File: hdl/rsc_stat_counters.sv */
// Per-port repeater statistics: event counters, source address registers
// and the byte-serial command/data port that reads and writes them.
// Assumes all event inputs and port strobes come from logic on i_clk.
`timescale 1ns/1ns

module rsc_stat_counters
  import rsc_pkg::*;
#(
  parameter logic [`RSC_JAB_CNT_W-1:0] JAB_CYCLES =
    `RSC_JAB_CNT_W'(`RSC_JABBER_TIME_US * `RSC_CLK_MHZ)
)
(
  // Clock, reset and clock enable.
  input  wire logic                      i_clk,
  input  wire logic                      i_arst_n,
  input  wire logic                      i_ce,
  // Node processor command/data port.
  input  wire logic                      i_np_strobe,
  input  wire logic                      i_np_cmd,
  input  wire logic                      i_np_write,
  input  wire logic [7:0]                i_np_wdata,
  output logic      [7:0]                o_np_rdata,
  // Write permission and port state.
  input  wire logic                      i_wr_perm,
  input  wire logic [`RSC_NUM_PORTS-1:0] i_port_dis,
  input  wire logic [`RSC_NUM_PORTS-1:0] i_sa_int_en,
  // Frame completion events.
  input  wire logic                      i_frm_end,
  input  wire logic [3:0]                i_frm_port,
  input  wire logic [10:0]               i_frm_len,
  input  wire logic                      i_frm_crc_bad,
  input  wire logic                      i_frm_align_err,
  input  wire logic                      i_frm_col,
  input  wire logic                      i_frm_rate_err,
  input  wire logic                      i_frm_bcast,
  input  wire logic                      i_frm_mcast,
  input  wire logic [`RSC_SA_W-1:0]      i_frm_sa,
  // Activity burst events.
  input  wire logic                      i_act_end,
  input  wire logic [3:0]                i_act_port,
  input  wire logic [9:0]                i_act_bits,
  // Collision events.
  input  wire logic                      i_col_det,
  input  wire logic                      i_col_carrier,
  input  wire logic [3:0]                i_col_port,
  input  wire logic [9:0]                i_col_bits,
  // Partition events.
  input  wire logic                      i_part_evt,
  input  wire logic [3:0]                i_part_port,
  // Transmitter activity.
  input  wire logic                      i_tx_active,
  input  wire logic [3:0]                i_tx_port,
  // Source address interrupt.
  output logic      [`RSC_NUM_PORTS-1:0] o_sa_int
);

  rsc_state_type s_q;
  rsc_state_type s_d;
  logic          jab_expire;

  // ****************************************
  // Decoding helpers.
  // ****************************************
  function automatic logic [3:0] cnt_index(input logic [7:0] addr);
    case (addr)
      `RSC_ADDR_OCTET:    cnt_index = `RSC_CI_OCTET;
      `RSC_ADDR_CRC:      cnt_index = `RSC_CI_CRC;
      `RSC_ADDR_ALIGN:    cnt_index = `RSC_CI_ALIGN;
      `RSC_ADDR_OVERSIZE: cnt_index = `RSC_CI_OVERSIZE;
      `RSC_ADDR_SHORT:    cnt_index = `RSC_CI_SHORT;
      `RSC_ADDR_FRAG:     cnt_index = `RSC_CI_FRAG;
      `RSC_ADDR_COLL:     cnt_index = `RSC_CI_COLL;
      `RSC_ADDR_LATE:     cnt_index = `RSC_CI_LATE;
      `RSC_ADDR_JABBER:   cnt_index = `RSC_CI_JABBER;
      `RSC_ADDR_RATE:     cnt_index = `RSC_CI_RATE;
      `RSC_ADDR_PART:     cnt_index = `RSC_CI_PART;
      `RSC_ADDR_SACHG:    cnt_index = `RSC_CI_SACHG;
      `RSC_ADDR_BCAST:    cnt_index = `RSC_CI_BCAST;
      `RSC_ADDR_MCAST:    cnt_index = `RSC_CI_MCAST;
      default:            cnt_index = `RSC_CI_NONE;
    endcase
  endfunction : cnt_index

  function automatic logic is_sa_addr(input logic [7:0] addr);
    is_sa_addr = (addr == `RSC_ADDR_LAST_SA) || (addr == `RSC_ADDR_EXP_SA);
  endfunction : is_sa_addr

  function automatic logic port_ok(input logic [3:0] p);
    port_ok = (32'(p) < `RSC_NUM_PORTS);
  endfunction : port_ok

  // ****************************************
  // Jabber timer.
  // ****************************************
  rsc_jabber_timer #(
    .LIMIT       (JAB_CYCLES)
  ) u_jabber (
    .i_clk       (i_clk),
    .i_arst_n    (i_arst_n),
    .i_ce        (i_ce),
    .i_tx_active (i_tx_active),
    .o_expire    (jab_expire)
  );

  // ****************************************
  // Next state.
  // ****************************************
  always_comb
  begin
    logic                 frm_ok;
    logic                 frm_valid;
    logic                 frm_clean;
    logic [3:0]           ci;
    logic [3:0]           bp;
    logic [2:0]           nbytes;
    logic [`RSC_SA_W-1:0] aval;
    logic [`RSC_SA_W-1:0] wfull;
    frm_ok    = 1'b0;
    frm_valid = 1'b0;
    frm_clean = 1'b0;
    ci        = `RSC_CI_NONE;
    bp        = s_q.ctl.bank;
    nbytes    = `RSC_CNT_BYTES;
    aval      = '0;
    wfull     = '0;
    s_d       = s_q;
    if (i_ce)
    begin
      s_d.ctl.irq = '0;

      // Frame completion updates.
      frm_ok    = i_frm_end && port_ok(i_frm_port);
      frm_valid = frm_ok && !i_frm_col && (i_frm_len >= `RSC_MIN_FRAME_BYTES)
                  && (i_frm_len <= `RSC_MAX_FRAME_BYTES);
      frm_clean = frm_valid && !i_frm_crc_bad;
      if (frm_clean)
      begin
        s_d.attr.cnt[i_frm_port][`RSC_CI_OCTET] =
          s_q.attr.cnt[i_frm_port][`RSC_CI_OCTET] + {21'h000000, i_frm_len};
        if (i_frm_bcast)
        begin
          s_d.attr.cnt[i_frm_port][`RSC_CI_BCAST] =
            s_q.attr.cnt[i_frm_port][`RSC_CI_BCAST] + 32'h1;
        end
        if (i_frm_mcast && !i_frm_bcast)
        begin
          s_d.attr.cnt[i_frm_port][`RSC_CI_MCAST] =
            s_q.attr.cnt[i_frm_port][`RSC_CI_MCAST] + 32'h1;
        end
        if (i_frm_sa != s_q.attr.last_sa[i_frm_port])
        begin
          s_d.attr.cnt[i_frm_port][`RSC_CI_SACHG] =
            s_q.attr.cnt[i_frm_port][`RSC_CI_SACHG] + 32'h1;
          s_d.ctl.irq[i_frm_port] = i_sa_int_en[i_frm_port];
        end
        if (i_frm_sa != s_q.attr.exp_sa[i_frm_port])
        begin
          s_d.ctl.irq[i_frm_port] = i_sa_int_en[i_frm_port];
        end
        s_d.attr.last_sa[i_frm_port] = i_frm_sa;
      end
      if (frm_valid && i_frm_crc_bad && !i_frm_align_err)
      begin
        s_d.attr.cnt[i_frm_port][`RSC_CI_CRC] =
          s_q.attr.cnt[i_frm_port][`RSC_CI_CRC] + 32'h1;
      end
      if (frm_valid && i_frm_crc_bad && i_frm_align_err)
      begin
        s_d.attr.cnt[i_frm_port][`RSC_CI_ALIGN] =
          s_q.attr.cnt[i_frm_port][`RSC_CI_ALIGN] + 32'h1;
      end
      if (frm_ok && (i_frm_len > `RSC_MAX_FRAME_BYTES))
      begin
        s_d.attr.cnt[i_frm_port][`RSC_CI_OVERSIZE] =
          s_q.attr.cnt[i_frm_port][`RSC_CI_OVERSIZE] + 32'h1;
      end
      if (frm_ok && i_frm_rate_err && !i_frm_col && (i_frm_len >= `RSC_RATE_MIN_BYTES))
      begin
        s_d.attr.cnt[i_frm_port][`RSC_CI_RATE] =
          s_q.attr.cnt[i_frm_port][`RSC_CI_RATE] + 32'h1;
      end

      // Activity burst classification.
      if (i_act_end && port_ok(i_act_port))
      begin
        if (i_act_bits < `RSC_SHORT_LIMIT_BT)
        begin
          s_d.attr.cnt[i_act_port][`RSC_CI_SHORT] =
            s_q.attr.cnt[i_act_port][`RSC_CI_SHORT] + 32'h1;
        end
        else if (i_act_bits < `RSC_MIN_FRAME_BT)
        begin
          s_d.attr.cnt[i_act_port][`RSC_CI_FRAG] =
            s_q.attr.cnt[i_act_port][`RSC_CI_FRAG] + 32'h1;
        end
      end

      // Collisions and late collisions.
      if (i_col_det && i_col_carrier && port_ok(i_col_port))
      begin
        s_d.attr.cnt[i_col_port][`RSC_CI_COLL] =
          s_q.attr.cnt[i_col_port][`RSC_CI_COLL] + 32'h1;
        if (i_col_bits > `RSC_LATE_THRESH_BT)
        begin
          s_d.attr.cnt[i_col_port][`RSC_CI_LATE] =
            s_q.attr.cnt[i_col_port][`RSC_CI_LATE] + 32'h1;
        end
      end

      // Overlong transmissions and partitions.
      if (jab_expire && port_ok(i_tx_port))
      begin
        s_d.attr.cnt[i_tx_port][`RSC_CI_JABBER] =
          s_q.attr.cnt[i_tx_port][`RSC_CI_JABBER] + 32'h1;
      end
      if (i_part_evt && port_ok(i_part_port))
      begin
        s_d.attr.cnt[i_part_port][`RSC_CI_PART] =
          s_q.attr.cnt[i_part_port][`RSC_CI_PART] + 32'h1;
      end

      // Selected attribute value.
      ci = cnt_index(s_q.ctl.attr);
      if (is_sa_addr(s_q.ctl.attr))
      begin
        nbytes = `RSC_SA_BYTES;
      end
      if (s_q.ctl.attr == `RSC_ADDR_LAST_SA)
      begin
        aval = s_d.attr.last_sa[bp];
      end
      else if (s_q.ctl.attr == `RSC_ADDR_EXP_SA)
      begin
        aval = s_d.attr.exp_sa[bp];
      end
      else if (ci != `RSC_CI_NONE)
      begin
        aval = {16'h0000, s_d.attr.cnt[bp][ci]};
      end

      // Node processor port.
      if (i_np_strobe && i_np_cmd && i_np_write)
      begin
        s_d.ctl.ridx = 3'h0;
        s_d.ctl.widx = 3'h0;
        if (!s_q.ctl.phase)
        begin
          s_d.ctl.bank_ok = (i_np_wdata >= `RSC_BANK_FIRST) && (i_np_wdata <= `RSC_BANK_LAST);
          s_d.ctl.bank    = i_np_wdata[3:0];
          s_d.ctl.phase   = 1'b1;
        end
        else
        begin
          s_d.ctl.attr  = i_np_wdata;
          s_d.ctl.phase = 1'b0;
        end
      end
      else if (i_np_strobe && !i_np_cmd && !i_np_write)
      begin
        s_d.ctl.widx = 3'h0;
        if (!s_q.ctl.bank_ok || (ci == `RSC_CI_NONE && !is_sa_addr(s_q.ctl.attr)))
        begin
          s_d.ctl.rdata = 8'h00;
        end
        else if (s_q.ctl.ridx == 3'h0)
        begin
          s_d.ctl.hold  = aval;
          s_d.ctl.rdata = aval[7:0];
          s_d.ctl.ridx  = 3'h1;
        end
        else
        begin
          s_d.ctl.rdata = s_q.ctl.hold[{s_q.ctl.ridx, 3'h0} +: 8];
          s_d.ctl.ridx  = s_q.ctl.ridx + 3'h1;
          if (s_d.ctl.ridx == nbytes)
          begin
            s_d.ctl.ridx = 3'h0;
            s_d.ctl.hold = aval;
          end
        end
      end
      else if (i_np_strobe && !i_np_cmd && i_np_write)
      begin
        s_d.ctl.ridx = 3'h0;
        if (s_q.ctl.bank_ok && (is_sa_addr(s_q.ctl.attr) || ci != `RSC_CI_NONE))
        begin
          if (s_q.ctl.widx == nbytes - 3'h1)
          begin
            wfull        = {8'h00, s_q.ctl.wbuf};
            wfull[{s_q.ctl.widx, 3'h0} +: 8] = i_np_wdata;
            s_d.ctl.widx = 3'h0;
            if (i_wr_perm || i_port_dis[bp])
            begin
              if (s_q.ctl.attr == `RSC_ADDR_LAST_SA)
              begin
                s_d.attr.last_sa[bp] = wfull;
              end
              else if (s_q.ctl.attr == `RSC_ADDR_EXP_SA)
              begin
                s_d.attr.exp_sa[bp] = wfull;
              end
              else
              begin
                s_d.attr.cnt[bp][ci] = wfull[`RSC_CNT_W-1:0];
              end
            end
          end
          else
          begin
            s_d.ctl.wbuf[{s_q.ctl.widx, 3'h0} +: 8] = i_np_wdata;
            s_d.ctl.widx = s_q.ctl.widx + 3'h1;
          end
        end
      end
    end
  end

  // ****************************************
  // State register.
  // ****************************************
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s_q.ctl <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_np_rdata = s_q.ctl.rdata;
  assign o_sa_int   = s_q.ctl.irq;

endmodule : rsc_stat_counters

/* File: sim/rsc_stat_counters_checker.sv */
// Checker: port properties of the per-port statistics block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ns
`include "rsc_params.svh"

module rsc_stat_counters_checker
#(
  parameter logic [`RSC_JAB_CNT_W-1:0] JAB_CYCLES = 20'h00014
)
(
  // Clock and reset.
  input wire logic                      i_clk,
  input wire logic                      i_arst_n,
  input wire logic                      i_ce,
  // Command/data port.
  input wire logic                      i_np_strobe,
  input wire logic                      i_np_cmd,
  input wire logic                      i_np_write,
  input wire logic [7:0]                i_np_wdata,
  input wire logic [7:0]                o_np_rdata,
  // Frames and interrupt.
  input wire logic [`RSC_NUM_PORTS-1:0] i_sa_int_en,
  input wire logic                      i_frm_end,
  input wire logic [3:0]                i_frm_port,
  input wire logic [10:0]               i_frm_len,
  input wire logic                      i_frm_crc_bad,
  input wire logic                      i_frm_col,
  input wire logic [`RSC_NUM_PORTS-1:0] o_sa_int
);
  logic       rd_take;
  logic       frm_take;
  logic [7:0] attr_q;
  assign rd_take  = i_ce & i_np_strobe & ~i_np_cmd & ~i_np_write;
  assign frm_take = i_ce & i_frm_end;
  always_ff @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n) attr_q <= 8'h00;
    else if (i_ce & i_np_strobe & i_np_cmd & i_np_write) attr_q <= i_np_wdata;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  property p_int_en;
    |o_sa_int |-> (o_sa_int & ~$past(i_sa_int_en)) == '0;
  endproperty
  a_int_en: assert property (p_int_en)
    else $error("sa_int on masked port");
  property p_int_port;
    |o_sa_int |-> o_sa_int == (15'h0001 << $past(i_frm_port));
  endproperty
  a_int_port: assert property (p_int_port)
    else $error("sa_int on wrong port");
  property p_int_crc;
    |o_sa_int |-> $past(frm_take) && !$past(i_frm_crc_bad) && !$past(i_frm_col);
  endproperty
  a_int_crc: assert property (p_int_crc)
    else $error("sa_int without clean frame");
  property p_int_len;
    |o_sa_int |-> $past(i_frm_len) >= 11'h040 && $past(i_frm_len) <= 11'h5EE;
  endproperty
  a_int_len: assert property (p_int_len)
    else $error("sa_int on bad length");
  property p_int_one;
    $onehot0(o_sa_int);
  endproperty
  a_int_one: assert property (p_int_one)
    else $error("sa_int on several ports");
  property p_int_pulse;
    frm_take ##1 !frm_take |=> o_sa_int == '0;
  endproperty
  a_int_pulse: assert property (p_int_pulse)
    else $error("sa_int longer than one cycle");
  property p_rd_hold;
    !rd_take |=> $stable(o_np_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("rdata moved without a read");
  property p_rd_unmapped;
    rd_take && attr_q == 8'hE0 |=> o_np_rdata == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");

  c_read: cover property (rd_take);
  c_int: cover property (frm_take ##1 |o_sa_int);
  c_frame: cover property (frm_take && !i_frm_crc_bad);
endmodule : rsc_stat_counters_checker

/* File: sim/rsc_np_model.sv */
// Node processor model: byte-serial command and data accesses.
// Assumes the block takes a strobe at the rising edge of i_clk.
`timescale 1ns/1ns

module rsc_np_model
(
  // Clock and returned byte.
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  // Command/data port.
  output logic            o_strobe,
  output logic            o_cmd,
  output logic            o_write,
  output logic [7:0]      o_wdata,
  // Bytes handed to the bench monitor.
  output logic            o_got,
  output logic [7:0]      o_byte
);
  initial
  begin
    {o_strobe, o_cmd, o_write, o_got} = 4'h0;
    {o_wdata, o_byte} = 16'h5A00;
  end

  // One strobed access; released data lines show a changed value.
  task automatic acc(input logic c, input logic w, input logic [7:0] d);
    @(negedge i_clk);
    {o_strobe, o_cmd, o_write, o_wdata} = {1'b1, c, w, d};
    @(negedge i_clk);
    o_strobe = 1'b0;
    o_wdata  = ~d;
  endtask : acc

  task automatic sel(input logic [7:0] bank, input logic [7:0] attr);
    acc(1'b1, 1'b1, bank);
    acc(1'b1, 1'b1, attr);
  endtask : sel

  task automatic wr(input int n, input logic [47:0] val);
    for (int i = 0; i < n; i++)
      acc(1'b0, 1'b1, val[8*i +: 8]);
  endtask : wr

  task automatic rd(input int n, input logic chk, output logic [47:0] val);
    val = 48'h000000000000;
    for (int i = 0; i < n; i++)
    begin
      acc(1'b0, 1'b0, 8'h00);
      @(negedge i_clk);
      val[8*i +: 8] = i_rdata;
      {o_got, o_byte} = {chk, i_rdata};
      @(negedge i_clk);
      o_got = 1'b0;
    end
  endtask : rd
endmodule : rsc_np_model

/* File: sim/rsc_stat_counters_test.sv */
// Self-checking bench for the per-port statistics block.
// Assumes the block, its checker and the processor model are compiled.
`timescale 1ns/1ns
`include "rsc_params.svh"

module rsc_stat_counters_test;
  localparam logic [3:0] TP  = 4'h5;
  localparam int         JAB = 20;
  localparam logic [7:0] BK  = 8'h15;
  logic        clk = 1'b0, arst_n = 1'b0, wr_perm = 1'b1;
  logic [14:0] port_dis = '0, en = '1, sa_int;
  logic        fend = 0, fcrc = 0, falg = 0, fcol = 0, frate = 0, fbc = 0, fmc = 0;
  logic [10:0] flen = '0;
  logic [47:0] fsa = '0, rsa, esa, v;
  logic        aend = 0, cdet = 0, ccar = 0, pevt = 0, txa = 0, stb, cmd, wr, got, ok;
  logic [3:0]  aport = '0, cport = '0, pport = '0, txp = '0, fport = '0, p;
  logic [9:0]  abits = '0, cbits = '0;
  logic [7:0]  wd, rdata, gbyte;
  logic [31:0] base[14], r;
  logic [7:0]  q[$];
  int          n_fail = 0, compares = 0, dl[14];
  logic [10:0] lens[8] = '{11'h03F, 11'h040, 11'h5EE, 11'h5EF, 11'h1FF, 11'h200, 11'h100, 11'h400};
  logic [9:0]  bts[8] = '{10'h04B, 10'h04C, 10'h1FF, 10'h200, 10'h201, 10'h014, 10'h12C, 10'h384};

  always #4 clk = ~clk;

  rsc_stat_counters #(.JAB_CYCLES(20'h00014)) u_dut (.i_clk(clk), .i_arst_n(arst_n), .i_ce(1'b1),
    .i_np_strobe(stb), .i_np_cmd(cmd), .i_np_write(wr), .i_np_wdata(wd), .o_np_rdata(rdata),
    .i_wr_perm(wr_perm), .i_port_dis(port_dis), .i_sa_int_en(en), .i_frm_end(fend),
    .i_frm_port(fport), .i_frm_len(flen), .i_frm_crc_bad(fcrc), .i_frm_align_err(falg),
    .i_frm_col(fcol), .i_frm_rate_err(frate), .i_frm_bcast(fbc), .i_frm_mcast(fmc),
    .i_frm_sa(fsa), .i_act_end(aend), .i_act_port(aport), .i_act_bits(abits),
    .i_col_det(cdet), .i_col_carrier(ccar), .i_col_port(cport), .i_col_bits(cbits),
    .i_part_evt(pevt), .i_part_port(pport), .i_tx_active(txa), .i_tx_port(txp),
    .o_sa_int(sa_int));
  rsc_np_model u_np (.i_clk(clk), .i_rdata(rdata), .o_strobe(stb), .o_cmd(cmd), .o_write(wr),
    .o_wdata(wd), .o_got(got), .o_byte(gbyte));

  task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic push(input int n, input logic [47:0] val);
    for (int i = 0; i < n; i++) q.push_back(val[8*i +: 8]);
  endtask : push

  task automatic sa_rd(input logic [7:0] a, input logic [47:0] val);
    u_np.sel(BK, a);
    push(6, val);
    u_np.rd(6, 1'b1, v);
  endtask : sa_rd

  task automatic frm(input logic [3:0] pt, input logic [10:0] len, input logic [5:0] f,
    input logic [47:0] sa);
    logic        vd;
    logic        g;
    logic [14:0] ei;
    vd = pt == TP && !f[3] && len >= 11'h040 && len <= 11'h5EE;
    g  = vd && !f[5];
    @(negedge clk);
    {fport, fcrc, falg, fcol, frate, fbc, fmc, flen, fsa, fend} = {pt, f, len, sa, 1'b1};
    en = 15'($urandom);
    ei = (g && (sa !== rsa || sa !== esa) && en[TP]) ? 15'h0001 << TP : 15'h0000;
    if (g) dl[0] += len;
    dl[1] += vd && f[5] && !f[4];
    dl[2] += vd && f[5] && f[4];
    dl[3] += pt == TP && len > 11'h5EE;
    dl[9] += pt == TP && f[2] && !f[3] && len >= 11'h200;
    dl[11] += g && sa !== rsa;
    dl[12] += g && f[1];
    dl[13] += g && f[0] && !f[1];
    if (g) rsa = sa;
    @(negedge clk);
    fend = 1'b0;
    check("sa_int", 48'(sa_int), 48'(ei));
  endtask : frm

  task automatic evt(input int k, input logic [3:0] pt, input logic [9:0] b, input logic c);
    c = c | (b > 10'h200);
    @(negedge clk);
    {aport, cport, pport, abits, cbits, ccar} = {pt, pt, pt, b, b, c};
    {aend, cdet, pevt} = {k == 0, k == 1, k == 2};
    if (pt == TP && k == 0) dl[4] += b < 10'h04C;
    if (pt == TP && k == 0) dl[5] += b >= 10'h04C && b < 10'h200;
    if (pt == TP && k == 1) dl[6] += c;
    if (pt == TP && k == 1) dl[7] += b > 10'h200;
    if (pt == TP && k == 2) dl[10]++;
    @(negedge clk);
    {aend, cdet, pevt} = 3'b000;
  endtask : evt

  task automatic jab(input logic [3:0] pt, input int n);
    @(negedge clk);
    {txp, txa} = {pt, 1'b1};
    repeat (n) @(negedge clk);
    txa = 1'b0;
    if (pt == TP && n > JAB) dl[8]++;
  endtask : jab

  always @(posedge clk)
    if (got === 1'b1) check("rdata", 48'(gbyte), q.size() ? 48'(q.pop_front()) : 48'h1FF);

  initial
  begin
    repeat (100000) @(posedge clk);
    n_fail++;
    close_out();
  end

  initial
  begin
    void'($urandom(32'h4207));
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    {rsa, esa} = {48'h0A0B0C0D0E0F, 48'h112233445566};
    u_np.sel(BK, 8'hEE);
    u_np.wr(6, rsa);
    u_np.sel(BK, 8'hF0);
    u_np.wr(6, esa);
    sa_rd(8'hEE, rsa);
    sa_rd(8'hF0, esa);
    u_np.sel(BK, 8'hEE);
    u_np.wr(3, 48'hBADBADBADBAD);
    sa_rd(8'hEE, rsa);
    for (int k = 0; k < 2; k++)
    begin
      {wr_perm, port_dis[TP]} = {1'b0, k == 1};
      u_np.sel(BK, 8'hEE);
      u_np.wr(6, 48'hC0FFEE00BEEF);
      if (k == 1) rsa = 48'hC0FFEE00BEEF;
      sa_rd(8'hEE, rsa);
    end
    {port_dis, wr_perm} = {15'h0000, 1'b1};
    @(negedge clk);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    sa_rd(8'hEE, rsa);
    sa_rd(8'hF0, esa);
    u_np.sel(8'h1F, 8'hE1);
    push(1, 48'h0);
    u_np.rd(1, 1'b1, v);
    u_np.sel(BK, 8'hE0);
    push(1, 48'h0);
    u_np.rd(1, 1'b1, v);
    for (int i = 0; i < 14; i++)
    begin
      u_np.sel(BK, (i == 13) ? 8'hEF : 8'hE1 + 8'(i));
      {base[i], dl[i]} = {$urandom | 32'hFFFF0000, 32'h0};
      u_np.wr(4, 48'(base[i]));
      push(4, 48'(base[i]));
      u_np.rd(4, 1'b1, v);
    end
    for (int i = 0; i < 150; i++)
    begin
      r = $urandom;
      p = r[18] ? TP : r[22:19];
      case (r[1:0])
        2'h1: evt(int'(r[3:2]) % 3, p, bts[r[26:24]], r[27]);
        2'h2: jab(p, r[4] ? JAB + 6 : JAB - 6);
        default: frm(r[15] ? 4'hF : TP, lens[r[7:5]], r[13:8], r[14] ? {16'h0000, r} : rsa);
      endcase
    end
    for (int i = 0; i < 14; i++)
    begin
      ok = !$isunknown(base[i]);
      if (!ok) $display("Counter %0d has no known start value; not compared", i);
      u_np.sel(BK, (i == 13) ? 8'hEF : 8'hE1 + 8'(i));
      repeat (2)
      begin
        if (ok) push(4, 48'(32'(base[i] + 32'(dl[i]))));
        u_np.rd(4, ok, v);
      end
    end
    sa_rd(8'hEE, rsa);
    sa_rd(8'hF0, esa);
    check("queue", 48'(q.size()), 48'h0);
    close_out();
  end
endmodule : rsc_stat_counters_test

bind rsc_stat_counters rsc_stat_counters_checker #(.JAB_CYCLES(JAB_CYCLES)) u_chk (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_np_strobe(i_np_strobe),
  .i_np_cmd(i_np_cmd), .i_np_write(i_np_write), .i_np_wdata(i_np_wdata),
  .o_np_rdata(o_np_rdata), .i_sa_int_en(i_sa_int_en), .i_frm_end(i_frm_end),
  .i_frm_port(i_frm_port), .i_frm_len(i_frm_len), .i_frm_crc_bad(i_frm_crc_bad),
  .i_frm_col(i_frm_col), .o_sa_int(o_sa_int));
